// ===== hdl/nvda_regs.sv
// Register front end for the byte-wide nonvolatile data memory.
// Notes on behaviour
// R1: Byte array, depth 32, 64, 128 or 256.
// R2: Address register width matches array depth.
// R3: Upper address bits ignore writes, read zero.
// R4: Array reachable only through these registers.
// R5: Each access moves one addressed byte.
// R6: Address and data registers directly accessed, bank 0.
// R7: Control register only via indirect port one.
// R8: Software loads pointer 40H and bank 01H.
// R9: Control bits: program/fetch permit and start.
// R10: Control upper bits zero; reset clears all.
// R11: Write starts only with permit; auto-clears.
// R12: Read starts only with permit; auto-clears.
// R13: Software never sets both starts together.
// R14: Address and data registers not reset.
// R15: Data register holds last transferred byte.
`timescale 1ns/1ps
`default_nettype none
module nvda_regs #(
  parameter int DEPTH          = 256,
  parameter int PROGRAM_CYCLES = nvda_pkg::NVDA_PROGRAM_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       addr_wr,          // Direct write to address register, bank 0.
  input  wire logic       byte_wr,          // Direct write to data register, bank 0.
  input  wire logic       indirect_one_wr,  // Write through indirect_port_one.
  input  wire logic [7:0] pointer_one,      // Current memory pointer one.
  input  wire logic [7:0] bank_select,      // Current bank select register.
  input  wire logic [7:0] wdata,            // CPU write data.
  output logic      [7:0] nv_address_reg,   // Address register read value.
  output logic      [7:0] nv_byte_reg,      // Data register read value.
  output logic      [7:0] indirect_one_rdata, // Read value at indirect_port_one.
  output logic            busy              // High during an array cycle.
);
  import nvda_pkg::*;

  localparam int AW = $clog2(DEPTH);  // R2

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Only the four documented depths are served.
  if (DEPTH != 32 && DEPTH != 64 && DEPTH != 128 && DEPTH != 256)
  begin : g_bad_depth
    $error("Array depth must be 32, 64, 128 or 256.");
  end
  if (PROGRAM_CYCLES < 1)
  begin : g_bad_time
    $error("Write time must be at least one cycle.");
  end

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  // True when the indirect port addresses the control register.
  function automatic logic hits_control(input logic [7:0] ptr, input logic [7:0] bank);
    hits_control = (ptr == NVDA_CONTROL_OFFSET) && (bank == NVDA_CONTROL_BANK);
  endfunction

  logic            ctrl_hit;        // Indirect access lands on control register.
  logic            ctrl_wr;         // Control register write strobe.
  logic [AW-1:0]   addr_q;          // Implemented address bits.
  logic [7:0]      byte_q;          // Data register.
  logic            program_permit;  // Write permit bit.
  logic            program_start;   // Write start bit.
  logic            fetch_permit;    // Read permit bit.
  logic            fetch_start;     // Read start bit.
  nvda_state_type  state;           // Sequencer state.
  logic [$clog2(PROGRAM_CYCLES+NVDA_FETCH_CYCLES+1)-1:0] count; // Cycle timer.
  logic            timer_done;      // Timer reached its last cycle.
  logic            byte_known;      // Data register loaded since the last reset.

  // Only the pointer-plus-bank path reaches the control register.
  assign ctrl_hit = hits_control(pointer_one, bank_select);  // R7 R8
  assign ctrl_wr  = indirect_one_wr && ctrl_hit;             // R7

  nvda_array_if #(.ADDR_WIDTH(AW)) arr ();

  // The array has no bus of its own; only this block drives it.
  nvda_array #(.DEPTH(DEPTH)) u_array (
    .clk  (clk),
    .port (arr)
  );  // R1 R4

  assign arr.addr  = addr_q;                           // R5
  assign arr.wdata = byte_q;                           // R5
  assign arr.wr_en = (state == NVDA_PROGRAM) && timer_done; // R11

  // ------------------------------------------------------------
  // Address register
  // ------------------------------------------------------------
  // Not reset; upper bits are simply not stored. Locked while a cycle runs.
  always_ff @(posedge clk)
  begin
    if (addr_wr && state == NVDA_IDLE)
    begin
      addr_q <= wdata[AW-1:0];  // R3 R6 R14
    end
  end

  // Unimplemented bits read as zero.
  always_comb
  begin
    nv_address_reg = '0;
    nv_address_reg[AW-1:0] = addr_q;  // R3
  end

  // ------------------------------------------------------------
  // Data register
  // ------------------------------------------------------------
  // Not reset; a finished read or a CPU write while idle replaces it, otherwise it holds.
  always_ff @(posedge clk)
  begin
    if (state == NVDA_FETCH && timer_done)
    begin
      byte_q <= arr.rdata;  // R12 R15
    end
    else if (byte_wr && state == NVDA_IDLE)
    begin
      byte_q <= wdata;      // R6 R14
    end
  end
  assign nv_byte_reg = byte_q;

  // The data register powers up unknown, so the hold check only starts once a
  // byte has really been placed in it by the CPU or by a finished read.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      byte_known <= 1'b0;
    end
    else if ((byte_wr && state == NVDA_IDLE) || (state == NVDA_FETCH && timer_done))
    begin
      byte_known <= 1'b1;  // R15
    end
  end

  // ------------------------------------------------------------
  // Control register and sequencer
  // ------------------------------------------------------------
  // Start bits only take when their permit is set; hardware clears them at the end.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      program_permit <= 1'b0;  // R10
      program_start  <= 1'b0;
      fetch_permit   <= 1'b0;
      fetch_start    <= 1'b0;
      state          <= NVDA_IDLE;
      count          <= '0;
    end
    else
    begin
      unique case (state)
        NVDA_IDLE:
        begin
          if (ctrl_wr)
          begin
            program_permit <= wdata[NVDA_PROGRAM_PERMIT_BIT];  // R9
            fetch_permit   <= wdata[NVDA_FETCH_PERMIT_BIT];
            // Write wins if software breaks the one-start-at-a-time rule.
            if (wdata[NVDA_PROGRAM_START_BIT] && wdata[NVDA_PROGRAM_PERMIT_BIT])
            begin
              program_start <= 1'b1;  // R11 R13
              state         <= NVDA_PROGRAM;
              count         <= '0;
            end
            else if (wdata[NVDA_FETCH_START_BIT] && wdata[NVDA_FETCH_PERMIT_BIT])
            begin
              fetch_start <= 1'b1;    // R12
              state       <= NVDA_FETCH;
              count       <= '0;
            end
          end
        end
        NVDA_FETCH, NVDA_PROGRAM:
        begin
          // Permits stay writable during a cycle; starts cannot be cleared early.
          if (ctrl_wr)
          begin
            program_permit <= wdata[NVDA_PROGRAM_PERMIT_BIT];
            fetch_permit   <= wdata[NVDA_FETCH_PERMIT_BIT];
          end
          count <= count + 1'b1;
          if (timer_done)
          begin
            program_start <= 1'b0;  // R11
            fetch_start   <= 1'b0;  // R12
            state         <= NVDA_IDLE;
          end
        end
        default:
        begin
          state <= NVDA_IDLE;
        end
      endcase
    end
  end

  // Read needs the registered array byte, hence a fixed multi-cycle latency.
  assign timer_done = (state == NVDA_PROGRAM)
    ? (count == ($bits(count))'(PROGRAM_CYCLES - 1))
    : (count == ($bits(count))'(NVDA_FETCH_CYCLES - 1));

  // Indirect read value: control bits, upper nibble zero.
  always_comb
  begin
    indirect_one_rdata = 8'h00;
    if (ctrl_hit)
    begin
      indirect_one_rdata = {4'h0, program_permit, program_start,
                            fetch_permit, fetch_start};  // R9 R10
    end
  end

  assign busy = (state != NVDA_IDLE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_write_gated;
    @(posedge clk) disable iff (reset)
      (state == NVDA_IDLE && !(ctrl_wr && wdata[NVDA_PROGRAM_PERMIT_BIT])) |=> !program_start;
  endproperty
  a_write_gated: assert property (p_write_gated) else $error("Write began without permit."); // R11

  property p_read_gated;
    @(posedge clk) disable iff (reset)
      (state == NVDA_IDLE && !(ctrl_wr && wdata[NVDA_FETCH_PERMIT_BIT])) |=> !fetch_start;
  endproperty
  a_read_gated: assert property (p_read_gated) else $error("Read began without permit."); // R12

  property p_read_clears;
    @(posedge clk) disable iff (reset)
      $rose(fetch_start) |-> ##[1:4] !fetch_start;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Read start never cleared."); // R12

  property p_upper_zero;
    @(posedge clk) disable iff (reset)
      indirect_one_rdata[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Control upper bits not zero."); // R10

  property p_addr_width;
    @(posedge clk) disable iff (reset)
      (nv_address_reg >> AW) == 8'h00;
  endproperty
  a_addr_width: assert property (p_addr_width) else $error("Unimplemented address bits set."); // R3

  property p_byte_holds;
    @(posedge clk) disable iff (reset)
      (byte_known && state == NVDA_IDLE && !byte_wr) |=> $stable(nv_byte_reg);
  endproperty
  a_byte_holds: assert property (p_byte_holds) else $error("Data register changed unasked."); // R15

  property p_one_start;
    @(posedge clk) disable iff (reset)
      !(program_start && fetch_start);
  endproperty
  a_one_start: assert property (p_one_start) else $error("Both starts active."); // R13

  property p_read_loads;
    @(posedge clk) disable iff (reset)
      (state == NVDA_FETCH && timer_done) |=> (nv_byte_reg == $past(arr.rdata));
  endproperty
  a_read_loads: assert property (p_read_loads) else $error("Read did not load data."); // R12
endmodule
`default_nettype wire

// ===== hdl/nvda_pkg.sv
// Package of constants and types for the nonvolatile data access register block.
package nvda_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] NVDA_CONTROL_OFFSET = 8'h40;  // Control register index inside bank 1.
  localparam logic [7:0] NVDA_CONTROL_BANK   = 8'h01;  // Bank that holds the control register.
  localparam logic [7:0] NVDA_CONTROL_RESET  = 8'h00;  // Control register value after reset.

  // ------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------
  localparam int NVDA_FETCH_START_BIT   = 0;  // Read start.
  localparam int NVDA_FETCH_PERMIT_BIT  = 1;  // Read permit.
  localparam int NVDA_PROGRAM_START_BIT = 2;  // Write start.
  localparam int NVDA_PROGRAM_PERMIT_BIT = 3; // Write permit.

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int NVDA_CLK_MHZ        = 125;  // System clock rate.
  localparam int NVDA_PROGRAM_TIME_US = 2;   // Array write time, a plain default.
  localparam int NVDA_PROGRAM_CYCLES =
    (NVDA_PROGRAM_TIME_US * NVDA_CLK_MHZ);   // Write time in clock cycles.
  localparam int NVDA_FETCH_CYCLES   = 2;    // Array read latency in clock cycles.

  // Sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    NVDA_IDLE     = 3'b001,
    NVDA_FETCH    = 3'b010,
    NVDA_PROGRAM  = 3'b100
  } nvda_state_type;

endpackage

// ===== hdl/nvda_array_if.sv
// Interface between the register front end and the byte array.
`timescale 1ns/1ps
`default_nettype none
interface nvda_array_if #(parameter int ADDR_WIDTH = 8);
  logic [ADDR_WIDTH-1:0] addr;    // Byte address.
  logic [7:0]            wdata;   // Byte to store.
  logic                  wr_en;   // Store strobe.
  logic [7:0]            rdata;   // Byte at addr, registered.

  modport ctrl  (output addr, output wdata, output wr_en, input rdata);
  modport store (input addr, input wdata, input wr_en, output rdata);
endinterface
`default_nettype wire

// ===== hdl/nvda_array.sv
// Byte-wide nonvolatile data array held in flip-flops.
`timescale 1ns/1ps
`default_nettype none
module nvda_array #(
  parameter int DEPTH = 256
) (
  input  wire logic     clk,
  nvda_array_if.store   port
);
  import nvda_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // The cells have no reset: stored content survives a reset as in the real part.
  logic [7:0] cells [DEPTH];

  // Writes land on the addressed byte; reads are registered.
  always_ff @(posedge clk)
  begin
    if (port.wr_en)
    begin
      cells[port.addr] <= port.wdata;  // R5
    end
    port.rdata <= cells[port.addr];    // R5
  end
endmodule
`default_nettype wire

// ===== test/nvda_cpu_model.sv
// CPU-side model that drives the register strobes of the block.
`timescale 1ns/1ps
`default_nettype none
module nvda_cpu_model (
  input  wire logic       clk,
  output logic            addr_wr,
  output logic            byte_wr,
  output logic            indirect_one_wr,
  output logic      [7:0] pointer_one,
  output logic      [7:0] bank_select,
  output logic      [7:0] wdata
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Idle bus at time zero, with bank 0 selected as after power-up.
  initial
  begin
    addr_wr         = 1'h0;
    byte_wr         = 1'h0;
    indirect_one_wr = 1'h0;
    pointer_one     = 8'h00;
    bank_select     = 8'h00;
    wdata           = 8'h00;
  end

  // One-cycle strobe: kind 0 address, 1 data, 2 control through port one.
  task automatic put(input int kind, input logic [7:0] val);
    if (kind == 2 && val[2] && val[0])
      val[0] = 1'h0;
    @(posedge clk);
    wdata           <= val;
    addr_wr         <= (kind == 0);
    byte_wr         <= (kind == 1);
    indirect_one_wr <= (kind == 2);
    @(posedge clk);
    {addr_wr, byte_wr, indirect_one_wr} <= 3'h0;
    // Released data does not keep the last value, so stale reuse shows up.
    wdata <= ~val;
  endtask

  // Load the pointer and bank before the control register is touched.
  task automatic point(input logic [7:0] p, input logic [7:0] b);
    @(posedge clk);
    pointer_one <= p;
    bank_select <= b;
  endtask
endmodule
`default_nettype wire

// ===== test/nvda_regs_tb.sv
// Self-checking testbench for the nonvolatile data access registers.
`timescale 1ns/1ps
`default_nettype none
module nvda_regs_tb;
  import nvda_pkg::*;
  localparam int DEPTH = 64;  // Six address bits kept, two dropped.
  typedef struct {logic [7:0] addr; logic [7:0] exp_addr; logic [7:0] data;} nvda_row_type;
  logic       clk;
  logic       reset;
  logic       addr_wr;
  logic       byte_wr;
  logic       indirect_one_wr;
  logic [7:0] pointer_one;
  logic [7:0] bank_select;
  logic [7:0] wdata;
  logic [7:0] nv_address_reg;
  logic [7:0] nv_byte_reg;
  logic [7:0] indirect_one_rdata;
  logic       busy;
  int         fail_count = 0;
  int         compares = 0;
  // Rows: written address, address read back, byte stored there.
  nvda_row_type rows [3] = '{'{8'hFF, 8'h3F, 8'hA5}, '{8'hC5, 8'h05, 8'h3C},
                             '{8'h2A, 8'h2A, 8'h5A}};

  // A short write time keeps the run brief.
  nvda_regs #(.DEPTH(DEPTH), .PROGRAM_CYCLES(4)) dut (.clk(clk), .reset(reset),
    .addr_wr(addr_wr), .byte_wr(byte_wr), .indirect_one_wr(indirect_one_wr),
    .pointer_one(pointer_one), .bank_select(bank_select), .wdata(wdata),
    .nv_address_reg(nv_address_reg), .nv_byte_reg(nv_byte_reg),
    .indirect_one_rdata(indirect_one_rdata), .busy(busy));
  nvda_cpu_model cpu (.clk(clk), .addr_wr(addr_wr), .byte_wr(byte_wr),
    .indirect_one_wr(indirect_one_wr), .pointer_one(pointer_one),
    .bank_select(bank_select), .wdata(wdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Free-running 8 ns clock.
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Control is sampled mid-cycle, away from the edge that updates it.
  task automatic ctrl_chk(input logic [7:0] exp);
    @(negedge clk);
    chk(indirect_one_rdata, exp);
  endtask

  // Start a cycle, see busy rise, then poll the start bit with a bound.
  task automatic run(input logic [7:0] val, input int sbit);
    int i;
    cpu.put(2, val);
    @(negedge clk);
    chk({7'h00, busy}, 8'h01);
    for (i = 0; i < 1000 && indirect_one_rdata[sbit] !== 1'h0; i++)
      @(negedge clk);
    if (i == 1000)
    begin
      fail_count++;
      stop_test();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset = 1'h1;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    cpu.point(8'h40, 8'h01);
    ctrl_chk(8'h00);
    chk({7'h00, busy}, 8'h00);
    // Store each row's byte, checking the trimmed address on the way.
    foreach (rows[i])
    begin
      cpu.put(0, rows[i].addr);
      @(negedge clk);
      chk(nv_address_reg, rows[i].exp_addr);
      cpu.put(1, rows[i].data);
      run(8'h0C, NVDA_PROGRAM_START_BIT);
      chk(indirect_one_rdata, 8'h08);
    end
    // Fetch them back after spoiling the data register each time.
    foreach (rows[i])
    begin
      cpu.put(0, rows[i].addr);
      cpu.put(1, ~rows[i].data);
      run(8'h03, NVDA_FETCH_START_BIT);
      chk(nv_byte_reg, rows[i].data);
      chk(indirect_one_rdata, 8'h02);
    end
    repeat (20) @(negedge clk);
    chk(nv_byte_reg, rows[2].data);
    // Starts without their permit in the same byte do nothing.
    cpu.put(2, 8'h04);
    ctrl_chk(8'h00);
    chk({7'h00, busy}, 8'h00);
    cpu.put(2, 8'h01);
    ctrl_chk(8'h00);
    chk(nv_byte_reg, rows[2].data);
    // Upper control bits never stick.
    cpu.put(2, 8'hF2);
    ctrl_chk(8'h02);
    // Wrong bank or wrong pointer must not reach the control register.
    cpu.point(8'h40, 8'h00);
    ctrl_chk(8'h00);
    cpu.point(8'h41, 8'h01);
    ctrl_chk(8'h00);
    cpu.point(8'h40, 8'h01);
    ctrl_chk(8'h02);
    // Reset in mid-write clears control and busy at once.
    cpu.put(2, 8'h0C);
    @(posedge clk);
    reset <= 1'h1;
    ctrl_chk(8'h00);
    chk({7'h00, busy}, 8'h00);
    @(posedge clk);
    reset <= 1'h0;
    // Stored bytes survive the reset and can still be fetched.
    cpu.put(0, rows[0].addr);
    run(8'h03, NVDA_FETCH_START_BIT);
    chk(nv_byte_reg, rows[0].data);
    stop_test();
  end
endmodule
`default_nettype wire
